// file: hw/rsi_map.svh
// Register offsets, field positions, reset values and timing figures of the
// relay status indication block.
// Assumes a 20 MHz system clock and a byte-addressed 32-bit register bus.
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH

// ==========================================================================
// Clock and timing figures
// ==========================================================================
`define RSI_CLK_HZ           20000000
`define RSI_MS_PER_S         1000
`define RSI_MS_CYCLES        (`RSI_CLK_HZ / `RSI_MS_PER_S)
`define RSI_LINK_PERIOD_MS   3000
`define RSI_LINK_BLANK_MS    200
`define RSI_THERM_PERIOD_MS  7000
`define RSI_THERM_FLASH_MS   200
`define RSI_FAULT_HALF_MS    250
`define RSI_FLICKER_HALF_MS  50
`define RSI_TMR_W            13

// ==========================================================================
// Overload warning thresholds, in hundredths of rated current
// ==========================================================================
`define RSI_WARN_3P_PCT      8'd114
`define RSI_WARN_1P_PCT      8'd85
`define RSI_UNBAL_LIMIT_PCT  7'd40
`define RSI_PCT_SCALE        8'd100

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define RSI_ADDR_CTRL        5'h00
`define RSI_ADDR_STATE       5'h04
`define RSI_ADDR_IRQ_STAT    5'h08
`define RSI_ADDR_IRQ_CLR     5'h0c
`define RSI_ADDR_IRQ_EN      5'h10

// CTRL fields
`define RSI_CTRL_MANUAL      0
`define RSI_CTRL_CONT        1
`define RSI_CTRL_RESET       2'h0

// IRQ fields (status, clear and enable share this layout)
`define RSI_IRQ_TRIP         0
`define RSI_IRQ_FAULT        1
`define RSI_IRQ_SUP_LOST     2
`define RSI_IRQ_SUP_BACK     3
`define RSI_IRQ_WARN         4
`define RSI_IRQ_W            5
`define RSI_IRQ_RESET        5'h00

// STATE fields
`define RSI_ST_RELAY_A       0
`define RSI_ST_RELAY_B       1
`define RSI_ST_WARN          2
`define RSI_ST_TRIP          3
`define RSI_ST_FAULT         4
`define RSI_ST_SUPPLY        5
`define RSI_ST_REARM         6
`define RSI_ST_CONT          7

`endif

// file: hw/rsi_pkg.sv
// Types shared by the relay status indication block.
// Assumes rsi_map.svh holds all numeric figures.
package rsi_pkg;

  // Auxiliary relay control state
  typedef enum logic [1:0] {
    RSI_RLY_OFF,
    RSI_RLY_HOLD,
    RSI_RLY_RUN
  } rsi_rly_state_t;

endpackage

// file: hw/rsi_top.sv
// Status LEDs and auxiliary relay control of a solid-state overload relay.
// Assumes trip, fault, current and command inputs come from logic on mclk;
// the supply sense and panel buttons are asynchronous pins.
//
// Contract
// - Four status LEDs show operating state
// - Ready, no trip: green, relays commanded
// - Link active: green blanked 200ms every 3s
// - Non-ack fault: three LEDs flash, red, open
// - Thermistor off: red flash every 7s
// - Warning: overload LED flickers, relays unchanged
// - Warning threshold 1.14 or 0.85 rated
// - Supply failed: LED dark, contacts open
// - Test fail or fault: red, contacts open
// - Relays de-energised without supply
// - NO contact then downstream changeover
// - Supply loss drops both relays
// - Automatic: pending commands applied on return
// - Manual: relays off until button pressed
// - Panel restarts in jog mode
`timescale 1ns/1ps
`include "rsi_map.svh"

module rsi_top
  import rsi_pkg::*;
#(
  parameter int MS_CYCLES = `RSI_MS_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // Asynchronous pins
  input  wire logic        supply_ok,
  input  wire logic        btn_dir1,
  input  wire logic        btn_dir2,
  // Protection logic on mclk
  input  wire logic        link_active,
  input  wire logic        trip_gnd,
  input  wire logic        trip_therm,
  input  wire logic        trip_ovl,
  input  wire logic        fault_nonack,
  input  wire logic        test_fail,
  input  wire logic        dev_fault,
  input  wire logic        therm_off,
  input  wire logic [15:0] load_current,
  input  wire logic [15:0] rated_current,
  input  wire logic        three_pole,
  input  wire logic [6:0]  unbalance_pct,
  // Switching commands from the IO-Link master
  input  wire logic        cmd_dir1,
  input  wire logic        cmd_dir2,
  // LEDs and relays
  output logic             led_dev_green,
  output logic             led_dev_red,
  output logic             led_gnd,
  output logic             led_therm,
  output logic             led_ovl,
  output logic             relay_a,
  output logic             relay_b,
  output logic             path_no_closed,
  output logic             path_nc_closed
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_prev_reg;
  logic       sup_s;
  logic       b1_s;
  logic       b2_s;
  logic       b1_rise;
  logic       b2_rise;

  // Two sync flops per pin; edge detect compares the second stage with a third, delayed flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {btn_dir2, btn_dir1, supply_ok};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign sup_s   = pin_sync_reg[0];
  assign b1_s    = pin_sync_reg[1];
  assign b2_s    = pin_sync_reg[2];
  assign b1_rise = pin_sync_reg[1] & ~pin_prev_reg[1];
  assign b2_rise = pin_sync_reg[2] & ~pin_prev_reg[2];

  // ==========================================================================
  // Millisecond tick and pattern timers
  // ==========================================================================
  localparam int TICK_W = $clog2(MS_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);

  logic [TICK_W-1:0]       tick_cnt_reg;
  logic                    ms_tick;
  logic [`RSI_TMR_W-1:0]   link_tmr_reg;
  logic [`RSI_TMR_W-1:0]   therm_tmr_reg;
  logic [`RSI_TMR_W-1:0]   fault_tmr_reg;
  logic [`RSI_TMR_W-1:0]   flick_tmr_reg;
  logic                    fault_phase_reg;
  logic                    flick_phase_reg;

  assign ms_tick = (tick_cnt_reg == TICK_LAST);

  // Divider: one-cycle enable per millisecond
  always_ff @(posedge mclk) begin
    if (srst || ms_tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // Link blank window: 200 ms dark at the start of each 3 s period
  always_ff @(posedge mclk) begin
    if (srst || !link_active) begin
      link_tmr_reg <= '0;
    end else if (ms_tick) begin
      if (link_tmr_reg == `RSI_TMR_W'(`RSI_LINK_PERIOD_MS - 1)) begin
        link_tmr_reg <= '0;
      end else begin
        link_tmr_reg <= link_tmr_reg + 1'b1;
      end
    end
  end

  // Thermistor-off flash: short red pulse once every 7 s
  always_ff @(posedge mclk) begin
    if (srst || !therm_off) begin
      therm_tmr_reg <= '0;
    end else if (ms_tick) begin
      if (therm_tmr_reg == `RSI_TMR_W'(`RSI_THERM_PERIOD_MS - 1)) begin
        therm_tmr_reg <= '0;
      end else begin
        therm_tmr_reg <= therm_tmr_reg + 1'b1;
      end
    end
  end

  // Fault flash and warning flicker square waves run free
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_tmr_reg   <= '0;
      fault_phase_reg <= 1'b1;
    end else if (ms_tick) begin
      if (fault_tmr_reg == `RSI_TMR_W'(`RSI_FAULT_HALF_MS - 1)) begin
        fault_tmr_reg   <= '0;
        fault_phase_reg <= ~fault_phase_reg;
      end else begin
        fault_tmr_reg <= fault_tmr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flick_tmr_reg   <= '0;
      flick_phase_reg <= 1'b1;
    end else if (ms_tick) begin
      if (flick_tmr_reg == `RSI_TMR_W'(`RSI_FLICKER_HALF_MS - 1)) begin
        flick_tmr_reg   <= '0;
        flick_phase_reg <= ~flick_phase_reg;
      end else begin
        flick_tmr_reg <= flick_tmr_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Operating state decode
  // ==========================================================================
  logic [23:0] load_scaled;
  logic [23:0] warn_level;
  logic        three_pole_bal;
  logic        warn_now;
  logic        any_trip;
  logic        dev_bad;
  logic        block_relays;

  // Compare in hundredths so no divider is needed
  assign three_pole_bal = three_pole && (unbalance_pct <= `RSI_UNBAL_LIMIT_PCT);
  assign load_scaled    = load_current * `RSI_PCT_SCALE;
  assign warn_level     = rated_current * (three_pole_bal ? `RSI_WARN_3P_PCT
                                                          : `RSI_WARN_1P_PCT);
  assign warn_now       = (rated_current != 16'h0000) && (load_scaled >= warn_level);
  assign any_trip       = trip_gnd | trip_therm | trip_ovl;
  assign dev_bad        = fault_nonack | test_fail | dev_fault;
  // Anything that must force both contact paths open
  assign block_relays   = !sup_s || any_trip || dev_bad;

  // ==========================================================================
  // Software control register and panel mode
  // ==========================================================================
  logic [1:0] ctrl_reg;
  logic       cont_mode_reg;
  logic       manual_mode;
  logic       wr_ack;
  logic       sup_lost;
  logic       sup_back;
  logic       sup_prev_reg;

  assign manual_mode = ctrl_reg[`RSI_CTRL_MANUAL];
  assign sup_lost    = sup_prev_reg & ~sup_s;
  assign sup_back    = ~sup_prev_reg & sup_s;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sup_prev_reg <= 1'b0;
    end else begin
      sup_prev_reg <= sup_s;
    end
  end

  // Continuous mode is dropped whenever supply is absent, so a return starts in jog
  always_ff @(posedge mclk) begin
    if (srst || !sup_s) begin
      cont_mode_reg <= 1'b0;
    end else if (wr_ack && avs_address == `RSI_ADDR_CTRL && avs_byteenable[0]) begin
      cont_mode_reg <= avs_writedata[`RSI_CTRL_CONT];
    end
  end

  // Manual selection survives a supply loss; it decides the restart behaviour
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= `RSI_CTRL_RESET;
    end else if (wr_ack && avs_address == `RSI_ADDR_CTRL && avs_byteenable[0]) begin
      ctrl_reg <= avs_writedata[1:0];
    end
  end

  // ==========================================================================
  // Relay control
  // ==========================================================================
  rsi_rly_state_t rly_state_reg;
  logic           cont_a_reg;
  logic           cont_b_reg;
  logic           want_a;
  logic           want_b;

  // Relays stay off after a manual-mode restart until a button press
  always_ff @(posedge mclk) begin
    if (srst) begin
      rly_state_reg <= RSI_RLY_OFF;
    end else begin
      case (rly_state_reg)
        RSI_RLY_OFF: begin
          if (sup_s) begin
            rly_state_reg <= manual_mode ? RSI_RLY_HOLD : RSI_RLY_RUN;
          end
        end
        RSI_RLY_HOLD: begin
          if (!sup_s) begin
            rly_state_reg <= RSI_RLY_OFF;
          end else if (!manual_mode || b1_rise || b2_rise) begin
            rly_state_reg <= RSI_RLY_RUN;
          end
        end
        RSI_RLY_RUN: begin
          if (!sup_s) begin
            rly_state_reg <= RSI_RLY_OFF;
          end
        end
        default: rly_state_reg <= RSI_RLY_OFF;
      endcase
    end
  end

  // Continuous panel mode: each press toggles that direction
  always_ff @(posedge mclk) begin
    if (srst || !sup_s || !cont_mode_reg || !manual_mode) begin
      cont_a_reg <= 1'b0;
      cont_b_reg <= 1'b0;
    end else begin
      if (b1_rise) begin
        cont_a_reg <= ~cont_a_reg;
      end
      if (b2_rise) begin
        cont_b_reg <= ~cont_b_reg;
      end
    end
  end

  // Commanded state: IO-Link commands in automatic, panel in manual
  always_comb begin
    if (!manual_mode) begin
      want_a = cmd_dir1;
      want_b = cmd_dir2;
    end else if (cont_mode_reg) begin
      want_a = cont_a_reg;
      want_b = cont_b_reg;
    end else begin
      want_a = b1_s;
      want_b = b2_s;
    end
  end

  // Relays are energised only in RUN and never without supply
  always_ff @(posedge mclk) begin
    if (srst) begin
      relay_a <= 1'b0;
      relay_b <= 1'b0;
    end else if (block_relays || rly_state_reg != RSI_RLY_RUN) begin
      relay_a <= 1'b0;
      relay_b <= 1'b0;
    end else begin
      relay_a <= want_a;
      relay_b <= want_b;
    end
  end

  // Changeover contact sits downstream of the NO contact
  assign path_no_closed = relay_a & relay_b;
  assign path_nc_closed = relay_a & ~relay_b;

  // ==========================================================================
  // LED drive
  // ==========================================================================
  logic link_blank;
  logic therm_flash;

  assign link_blank  = link_active && (link_tmr_reg < `RSI_TMR_W'(`RSI_LINK_BLANK_MS));
  assign therm_flash = therm_tmr_reg < `RSI_TMR_W'(`RSI_THERM_FLASH_MS);

  // Priority: no supply, non-ack fault, trip or test/device fault, then normal indications
  always_ff @(posedge mclk) begin
    if (srst) begin
      led_dev_green <= 1'b0;
      led_dev_red   <= 1'b0;
      led_gnd       <= 1'b0;
      led_therm     <= 1'b0;
      led_ovl       <= 1'b0;
    end else if (!sup_s) begin
      led_dev_green <= 1'b0;
      led_dev_red   <= 1'b0;
      led_gnd       <= 1'b0;
      led_therm     <= 1'b0;
      led_ovl       <= 1'b0;
    end else if (fault_nonack) begin
      led_dev_green <= 1'b0;
      led_dev_red   <= 1'b1;
      led_gnd       <= fault_phase_reg;
      led_therm     <= fault_phase_reg;
      led_ovl       <= fault_phase_reg;
    end else if (any_trip || test_fail || dev_fault) begin
      led_dev_green <= 1'b0;
      led_dev_red   <= 1'b1;
      led_gnd       <= trip_gnd;
      led_therm     <= trip_therm;
      led_ovl       <= trip_ovl;
    end else begin
      led_dev_green <= !link_blank;
      led_dev_red   <= 1'b0;
      led_gnd       <= 1'b0;
      led_therm     <= therm_off && therm_flash;
      led_ovl       <= warn_now && flick_phase_reg;
    end
  end

  // ==========================================================================
  // Interrupt status, clear and enable
  // ==========================================================================
  logic [`RSI_IRQ_W-1:0] irq_stat_reg;
  logic [`RSI_IRQ_W-1:0] irq_en_reg;
  logic [`RSI_IRQ_W-1:0] irq_set;
  logic [`RSI_IRQ_W-1:0] irq_clr;
  logic                  trip_prev_reg;
  logic                  fault_prev_reg;
  logic                  warn_prev_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      trip_prev_reg  <= 1'b0;
      fault_prev_reg <= 1'b0;
      warn_prev_reg  <= 1'b0;
    end else begin
      trip_prev_reg  <= any_trip;
      fault_prev_reg <= dev_bad;
      warn_prev_reg  <= warn_now;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[`RSI_IRQ_TRIP]     = any_trip & ~trip_prev_reg;
    irq_set[`RSI_IRQ_FAULT]    = dev_bad & ~fault_prev_reg;
    irq_set[`RSI_IRQ_SUP_LOST] = sup_lost;
    irq_set[`RSI_IRQ_SUP_BACK] = sup_back;
    irq_set[`RSI_IRQ_WARN]     = warn_now & ~warn_prev_reg;
  end

  assign irq_clr = (wr_ack && avs_address == `RSI_ADDR_IRQ_CLR && avs_byteenable[0])
                   ? avs_writedata[`RSI_IRQ_W-1:0] : '0;

  // Sticky bits; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_reg <= `RSI_IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en_reg <= `RSI_IRQ_RESET;
    end else if (wr_ack && avs_address == `RSI_ADDR_IRQ_EN && avs_byteenable[0]) begin
      irq_en_reg <= avs_writedata[`RSI_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // ==========================================================================
  // Avalon-MM slave: one wait state on every access
  // ==========================================================================
  logic        ack_reg;
  logic        rd_ack;
  logic [31:0] rd_mux;
  logic [7:0]  state_word;

  // Request held one cycle, then answered; ack drops so back-to-back works
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_ack          = avs_write && ack_reg;
  assign rd_ack          = avs_read && !ack_reg;

  always_comb begin
    state_word = '0;
    state_word[`RSI_ST_RELAY_A] = relay_a;
    state_word[`RSI_ST_RELAY_B] = relay_b;
    state_word[`RSI_ST_WARN]    = warn_now;
    state_word[`RSI_ST_TRIP]    = any_trip;
    state_word[`RSI_ST_FAULT]   = dev_bad;
    state_word[`RSI_ST_SUPPLY]  = sup_s;
    state_word[`RSI_ST_REARM]   = (rly_state_reg == RSI_RLY_HOLD);
    state_word[`RSI_ST_CONT]    = cont_mode_reg;
  end

  // Unmapped and write-only addresses read as zero
  always_comb begin
    case (avs_address)
      `RSI_ADDR_CTRL:     rd_mux = {30'h0, cont_mode_reg, ctrl_reg[`RSI_CTRL_MANUAL]};
      `RSI_ADDR_STATE:    rd_mux = {24'h0, state_word};
      `RSI_ADDR_IRQ_STAT: rd_mux = {27'h0, irq_stat_reg};
      `RSI_ADDR_IRQ_EN:   rd_mux = {27'h0, irq_en_reg};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, valid when waitrequest drops
  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_ack) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule

// file: dv/rsi_iol_model.sv
// IO-Link master model: link state and switching commands.
// Assumes the bench sets the wanted state; it shows after LAG cycles.
`timescale 1ns/1ps
module rsi_iol_model #(
  parameter int LAG = 1
) (
  input  wire logic       mclk,
  input  wire logic [2:0] want,
  output logic            link_active,
  output logic            cmd_dir1,
  output logic            cmd_dir2
);
  // ==========================================================
  // Command pipeline
  // ==========================================================
  logic [2:0] dly_reg [LAG];

  // Commands stand until changed, so they survive a supply dip
  always_ff @(posedge mclk) begin
    dly_reg[0] <= want;
    for (int i = 1; i < LAG; i++) begin
      dly_reg[i] <= dly_reg[i-1];
    end
  end

  assign {link_active, cmd_dir2, cmd_dir1} = dly_reg[LAG-1];
endmodule

// file: dv/rsi_top_sva.sv
// Port checks of the relay status indication block.
// Assumes one clock mclk and synchronous reset srst.
`timescale 1ns/1ps
module rsi_top_sva (
  input logic mclk,
  input logic srst,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic irq,
  input logic supply_ok,
  input logic link_active,
  input logic trip_gnd,
  input logic trip_therm,
  input logic trip_ovl,
  input logic fault_nonack,
  input logic test_fail,
  input logic dev_fault,
  input logic led_dev_green,
  input logic led_dev_red,
  input logic led_gnd,
  input logic led_therm,
  input logic led_ovl,
  input logic relay_a,
  input logic relay_b,
  input logic path_no_closed,
  input logic path_nc_closed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Contacts
  // ==========================================================
  // Supply needs four samples: two sync flops plus margin
  a_trip_opens: assert property ((trip_gnd || trip_therm || trip_ovl) |=> !relay_a && !relay_b)
    else $error("relay on during trip");
  a_fault_opens: assert property ((fault_nonack || test_fail || dev_fault) |=> !relay_a && !relay_b)
    else $error("relay on during fault");
  a_path_no: assert property (relay_a && relay_b |-> path_no_closed && !path_nc_closed)
    else $error("no path wrong");
  a_path_nc: assert property (!relay_b |-> path_nc_closed == relay_a && !path_no_closed)
    else $error("changeover path wrong");
  a_supply_drop: assert property (!supply_ok [*4] |=> !relay_a && !relay_b)
    else $error("relay on without supply");
  // ==========================================================
  // LEDs
  // ==========================================================
  a_dark_nosup: assert property (!supply_ok [*4] |=> !led_dev_green && !led_dev_red)
    else $error("device led lit without supply");
  a_green_ready: assert property (supply_ok [*6] ##0 !(trip_gnd || trip_therm || trip_ovl || fault_nonack
    || test_fail || dev_fault || link_active) |=> led_dev_green && !led_dev_red)
    else $error("ready not green");
  a_trip_cause: assert property (supply_ok [*6] ##0 (trip_gnd && !fault_nonack) |=> led_gnd && led_dev_red)
    else $error("ground trip leds wrong");
  a_flash_group: assert property (supply_ok [*6] ##0 fault_nonack [*2]
    |-> led_dev_red && led_gnd == led_therm && led_therm == led_ovl)
    else $error("fault leds not together");
  // ==========================================================
  // Bus
  // ==========================================================
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait on new request");
  c_trip: cover property (trip_gnd && led_gnd);
  c_blank: cover property (link_active && supply_ok && !led_dev_green && !led_dev_red);
  c_irq: cover property (irq);
endmodule

// file: dv/rsi_top_bench.sv
// Self-checking bench of the relay status indication block.
// Assumes rsi_top, the master model and the checker are compiled.
`timescale 1ns/1ps
`include "rsi_map.svh"
module rsi_top_bench;
  import rsi_pkg::*;
  localparam int MSC = 4;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        sup  = 1'b0;
  logic        fna  = 1'b0;
  logic        toff = 1'b0;
  logic        tp   = 1'b1;
  logic        rd   = 1'b0;
  logic        wr   = 1'b0;
  logic [1:0]  btn  = 2'h0;
  logic [4:0]  flt  = 5'h00;
  logic [6:0]  unb  = 7'h00;
  logic [4:0]  adr  = 5'h00;
  logic [2:0]  want = 3'h0;
  logic [15:0] load = 16'h0000;
  logic [15:0] rated = 16'h0064;
  logic [31:0] wd   = 32'h0;
  logic [31:0] rdata;
  wire  [31:0] rdv;
  wire         wreq, irq, lg, lr, lgn, lth, lov, ra, rb, pno, pnc, lnk, c1, c2;
  wire  [6:0]  leds = {lg, lr, lgn, lth, lov, ra, rb};
  int          miscompares = 0;
  int          tests_run = 0;
  // Table rows: three_pole, unbalance, load, warning expected
  logic [24:0] wtab [5] = '{{1'h1, 7'h28, 16'h0072, 1'h1}, {1'h1, 7'h28, 16'h0071, 1'h0},
    {1'h1, 7'h29, 16'h0055, 1'h1}, {1'h0, 7'h00, 16'h0055, 1'h1}, {1'h0, 7'h00, 16'h0054, 1'h0}};

  always #25 mclk = ~mclk;

  rsi_top #(.MS_CYCLES(MSC)) i_dut (
    .mclk(mclk), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdv), .avs_waitrequest(wreq),
    .irq(irq), .supply_ok(sup), .btn_dir1(btn[0]), .btn_dir2(btn[1]), .link_active(lnk),
    .trip_gnd(flt[0]), .trip_therm(flt[1]), .trip_ovl(flt[2]), .fault_nonack(fna),
    .test_fail(flt[3]), .dev_fault(flt[4]), .therm_off(toff), .load_current(load),
    .rated_current(rated), .three_pole(tp), .unbalance_pct(unb), .cmd_dir1(c1), .cmd_dir2(c2),
    .led_dev_green(lg), .led_dev_red(lr), .led_gnd(lgn), .led_therm(lth), .led_ovl(lov),
    .relay_a(ra), .relay_b(rb), .path_no_closed(pno), .path_nc_closed(pnc));

  // Slow master, two cycles of lag
  rsi_iol_model #(.LAG(2)) i_iol (.mclk(mclk), .want(want), .link_active(lnk), .cmd_dir1(c1), .cmd_dir2(c2));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Held until waitrequest is sampled low at a rising edge; data taken there, a free edge follows
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk);
    end while (wreq);
    rdata = rdv;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Windowed counts are taken at the falling edge, clear of updates
  initial begin
    int n;
    int g;
    int k;
    cyc(3);
    srst <= 1'b0;
    cyc(1);
    bus(1'b0, `RSI_ADDR_CTRL, 32'h0);
    chk(rdata, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    chk(rdata, 32'h0);
    sup <= 1'b1;
    want <= 3'h1;
    cyc(8);
    chk(leds, 7'h42);
    chk({pno, pnc}, 2'h1);
    want <= 3'h3;
    cyc(5);
    chk({pno, pnc}, 2'h2);
    bus(1'b1, `RSI_ADDR_IRQ_EN, 32'h1);
    for (int i = 0; i < 5; i++) begin
      flt <= 5'h01 << i;
      cyc(4);
      chk(leds, (i < 3) ? (7'h20 | (7'h10 >> i)) : 7'h20);
      chk(irq, 32'(i < 3));
      flt <= 5'h00;
      bus(1'b1, `RSI_ADDR_IRQ_CLR, 32'h1f);
    end
    // Masked event still leaves its sticky bit
    bus(1'b1, `RSI_ADDR_IRQ_EN, 32'h0);
    flt <= 5'h01;
    cyc(4);
    chk(irq, 32'h0);
    bus(1'b0, `RSI_ADDR_IRQ_STAT, 32'h0);
    chk(rdata, 32'h1);
    flt <= 5'h00;
    bus(1'b1, `RSI_ADDR_IRQ_CLR, 32'h1f);
    bus(1'b0, `RSI_ADDR_IRQ_STAT, 32'h0);
    chk(rdata, 32'h0);
    fna <= 1'b1;
    n = 0;
    k = 0;
    cyc(3);
    for (int i = 0; i < 250 * MSC * 2; i++) begin
      @(negedge mclk);
      n += lgn;
      k += (lgn !== lth) + (lth !== lov);
    end
    chk(32'(n > 990 && n < 1010 && k == 0), 32'h1);
    chk({lr, ra, rb}, 3'h4);
    @(posedge mclk);
    fna <= 1'b0;
    want <= 3'h7;
    toff <= 1'b1;
    g = 0;
    n = 0;
    for (int i = 0; i < 7000 * MSC; i++) begin
      @(negedge mclk);
      g += (i < 6000 * MSC) && !lg;
      n += lth;
    end
    chk(32'(g > 1595 && g < 1605), 32'h1);
    chk(32'(n > 795 && n < 805), 32'h1);
    chk({ra, rb}, 2'h3);
    @(posedge mclk);
    toff <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      {tp, unb, load} <= wtab[i][24:1];
      cyc(4);
      bus(1'b0, `RSI_ADDR_STATE, 32'h0);
      chk(rdata[`RSI_ST_WARN], wtab[i][0]);
      n = 0;
      for (int j = 0; j < 100 * MSC; j++) begin
        @(negedge mclk);
        n += lov;
      end
      chk(32'(n >= 198 * wtab[i][0] && n <= 202 * wtab[i][0] && ra && rb), 32'h1);
      @(posedge mclk);
    end
    load <= 16'h0000;
    bus(1'b1, `RSI_ADDR_IRQ_EN, 32'h4);
    sup <= 1'b0;
    cyc(6);
    chk(leds, 7'h00);
    chk(irq, 32'h1);
    sup <= 1'b1;
    cyc(8);
    chk({ra, rb}, 2'h3);
    bus(1'b1, `RSI_ADDR_CTRL, 32'h3);
    sup <= 1'b0;
    cyc(6);
    sup <= 1'b1;
    cyc(8);
    chk({ra, rb}, 2'h0);
    bus(1'b0, `RSI_ADDR_CTRL, 32'h0);
    chk(rdata, 32'h1);
    btn <= 2'h1;
    cyc(6);
    chk({ra, rb}, 2'h2);
    btn <= 2'h0;
    cyc(6);
    chk({ra, rb}, 2'h0);
    report_and_stop();
  end

  // The sequence needs about 32k cycles
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
endmodule

bind rsi_top rsi_top_sva i_sva (
  .mclk(mclk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .irq(irq), .supply_ok(supply_ok), .link_active(link_active), .trip_gnd(trip_gnd), .trip_therm(trip_therm),
  .trip_ovl(trip_ovl), .fault_nonack(fault_nonack), .test_fail(test_fail), .dev_fault(dev_fault),
  .led_dev_green(led_dev_green), .led_dev_red(led_dev_red), .led_gnd(led_gnd), .led_therm(led_therm),
  .led_ovl(led_ovl), .relay_a(relay_a), .relay_b(relay_b), .path_no_closed(path_no_closed),
  .path_nc_closed(path_nc_closed));
